// *** rtl/idrd_pkg.sv ***
// constants, field layouts and carriers for the id resistor detect register bank
package idrd_pkg;
   // immediate register command kinds in cmd[7:6], address in cmd[5:0]
   localparam logic [1:0] CMD_REG_WRITE = 2'h2;
   localparam logic [1:0] CMD_REG_READ = 2'h3;
   // register addresses
   localparam logic [5:0] ADDR_EVENT_LATCH = 6'h21;
   localparam logic [5:0] ADDR_VENDOR_LO = 6'h30;
   localparam logic [5:0] ADDR_VENDOR_HI = 6'h3f;
   localparam logic [5:0] ADDR_BOOST = 6'h31;
   localparam logic [5:0] ADDR_AUDIO_KEY = 6'h33;
   localparam logic [5:0] ADDR_CONV_WRITE = 6'h36;
   localparam logic [5:0] ADDR_CONV_SET = 6'h37;
   localparam logic [5:0] ADDR_CONV_CLEAR = 6'h38;
   // field positions
   localparam int LATCH_FLOAT_BIT = 0;
   localparam int LATCH_DONE_BIT = 3;
   localparam int BOOST_LSB = 5;
   localparam int CONV_DONE_BIT = 3;
   localparam int CONV_GO_BIT = 4;
   localparam int CONV_RSV_BIT = 5;
   localparam int CONV_IEN_BIT = 6;
   // writable bits: code 2:0, go, reserved 5, irq enable
   localparam logic [7:0] CONV_WRITE_MASK = 8'h77;
   localparam logic [7:0] LATCH_READ_MASK = 8'h09;
   localparam logic [3:0] AUDIO_KEY_VALUE = 4'ha;
   // reset values
   localparam logic [1:0] BOOST_RESET = 2'h0;
   localparam logic [3:0] AUDIO_KEY_RESET = 4'h0;
   localparam logic [2:0] CODE_RESET = 3'h0;
   // boost settings
   localparam logic [1:0] BOOST_NOMINAL = 2'h0;
   localparam logic [1:0] BOOST_PLUS_11P1 = 2'h1;
   localparam logic [1:0] BOOST_PLUS_7P4 = 2'h2;
   localparam logic [1:0] BOOST_PLUS_3P7 = 2'h3;
   // resistor codes as the converter reports them
   localparam logic [2:0] CODE_ZERO_OHM = 3'h0;
   localparam logic [2:0] CODE_75_OHM = 3'h1;
   localparam logic [2:0] CODE_100K = 3'h2;
   localparam logic [2:0] CODE_200K = 3'h3;
   localparam logic [2:0] CODE_440K = 3'h4;
   localparam logic [2:0] CODE_FLOATING = 3'h5;
   localparam logic [2:0] CODE_ERROR = 3'h7;
   // timing
   // cycles after reset before synchronised pin edges are believed
   localparam logic [1:0] SYNC_WARM_CYCLES = 2'h3;
   localparam int CLK_PERIOD_PS = 25000;
   localparam int CONV_TIME_US = 282;
   localparam int CONV_CYCLES = (CONV_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // register access carriers
   typedef struct packed {
      logic valid; // one-cycle command strobe
      logic [7:0] cmd; // command byte: kind and address
      logic [7:0] wdata; // write data
   } idrd_acc_t;
   typedef struct packed {
      logic valid; // one-cycle read answer
      logic [7:0] rdata; // read data
   } idrd_rsp_t;
endpackage

// *** rtl/idrd_sync2.sv ***
// two-flop synchroniser for asynchronous analog status levels
`timescale 1ns/10ps
module idrd_sync2 #(
   parameter int W = 4
) (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   typedef struct packed {
      logic [W-1:0] meta; // first stage, read only by the second
      logic [W-1:0] sync; // second stage
   } idrd_sync_t;
   idrd_sync_t st;
   idrd_sync_t next_st;
   // shift chain
   always_comb begin
      next_st.meta = i_async;
      next_st.sync = st.meta;
   end
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign o_sync = st.sync;
endmodule

// *** rtl/idrd_conv_timer.sv ***
// conversion duration timer: pulses once after CYCLES cycles of run
`timescale 1ns/10ps
module idrd_conv_timer #(
   parameter int CYCLES = 11280
) (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_run,
   output logic o_finish
);
   typedef struct packed {
      logic [15:0] cnt; // cycles spent measuring
      logic finish; // one-cycle completion pulse
   } idrd_tmr_t;
   idrd_tmr_t st;
   idrd_tmr_t next_st;
   // count while running; dropping run aborts and rearms the count
   always_comb begin
      next_st = st;
      next_st.finish = 1'b0;
      if (!i_run) begin
         next_st.cnt = '0;
      end else if (st.cnt == 16'(CYCLES - 1)) begin
         next_st.cnt = '0;
         next_st.finish = 1'b1;
      end else begin
         next_st.cnt = st.cnt + 16'h0001;
      end
   end
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign o_finish = st.finish;
endmodule

// *** rtl/idrd_regs.sv ***
// id float and resistor conversion register bank on the link clock
`timescale 1ns/10ps
module idrd_regs #(
   parameter int CONV_CYCLES_P = idrd_pkg::CONV_CYCLES // shorten in simulation
) (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire idrd_pkg::idrd_acc_t i_acc,
   input wire logic i_id_float,
   input wire logic [2:0] i_resistor_code_pin,
   input wire logic i_float_rising_irq_enable,
   input wire logic i_float_falling_irq_enable,
   input wire logic i_carkit_resistor_irq_enable,
   output idrd_pkg::idrd_rsp_t o_rsp,
   output logic o_alt_int,
   output logic [1:0] o_boost,
   output logic o_audio_mode_en,
   output logic o_resistor_measure_go,
   output logic [2:0] o_resistor_code,
   output logic o_resistor_measure_done
);
   import idrd_pkg::*;

   typedef enum logic {CONV_IDLE, CONV_RUN} idrd_conv_t;

   // whole state of the bank
   typedef struct packed {
      logic [1:0] boost; // transmit amplitude select
      logic [3:0] audio_mode_key; // headset audio key
      logic audio_en; // decoded key match
      logic [2:0] resistor_code; // last measured value
      logic resistor_measure_done; // conversion finished
      logic resistor_measure_go; // conversion requested / running
      logic rsv5; // stored, link keeps it zero
      logic resistor_done_irq_enable; // local copy of the enable
      logic id_float_event_flag; // latch bit 0
      logic resistor_done_event_flag; // latch bit 3
      logic float_prev; // last synchronised float level
      logic [1:0] warm; // cycles since reset, saturates once pins are trusted
      idrd_conv_t conv; // converter sequencing
      logic alt_int; // interrupt towards rxcmd
      idrd_rsp_t rsp; // read answer
   } idrd_state_t;

   idrd_state_t st;
   idrd_state_t next_st;
   logic [3:0] pins_sync; // {float, code} after two flops
   logic float_s; // synchronised float level
   logic pins_live; // both synchroniser stages now hold real pin levels
   logic [2:0] code_s; // synchronised converter output
   logic conv_fin; // timer completion pulse
   logic [1:0] cmd_kind; // command kind field
   logic [5:0] cmd_addr; // register address field
   logic acc_wr; // immediate register write taken
   logic acc_rd; // immediate register read taken
   logic float_evt; // enabled float edge this cycle
   logic done_evt; // enabled done rising this cycle
   logic irq_en_any; // combined resistor irq enable
   logic [7:0] conv_byte; // current conversion register image
   logic [7:0] conv_new; // conversion register after a write

   // true for any of the three conversion register aliases
   function automatic logic is_conv_addr(input logic [5:0] a);
      return (a == ADDR_CONV_WRITE) || (a == ADDR_CONV_SET) || (a == ADDR_CONV_CLEAR);
   endfunction

   // vendor window decode
   function automatic logic is_vendor_addr(input logic [5:0] a);
      return (a >= ADDR_VENDOR_LO) && (a <= ADDR_VENDOR_HI);
   endfunction

   // analog levels are asynchronous to the link clock
   idrd_sync2 #(
      .W(4)
   ) u_sync (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_async({i_id_float, i_resistor_code_pin}),
      .o_sync(pins_sync)
   );

   // times the measurement while the converter runs
   idrd_conv_timer #(
      .CYCLES(CONV_CYCLES_P)
   ) u_timer (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_run(st.conv == CONV_RUN),
      .o_finish(conv_fin)
   );

   assign float_s = pins_sync[3];
   assign code_s = pins_sync[2:0];
   assign pins_live = (st.warm == SYNC_WARM_CYCLES);
   assign cmd_kind = i_acc.cmd[7:6];
   assign cmd_addr = i_acc.cmd[5:0];
   assign acc_wr = i_acc.valid && (cmd_kind == CMD_REG_WRITE);
   assign acc_rd = i_acc.valid && (cmd_kind == CMD_REG_READ);
   assign irq_en_any = st.resistor_done_irq_enable | i_carkit_resistor_irq_enable;
   assign conv_byte = {1'b0, st.resistor_done_irq_enable, st.rsv5, st.resistor_measure_go,
                       st.resistor_measure_done, st.resistor_code};

   // float edges: either direction counts only while its own enable is on,
   // and only once the synchroniser has filled, so reset cannot fake an edge
   always_comb begin
      float_evt = 1'b0;
      if (pins_live && float_s && !st.float_prev && i_float_rising_irq_enable) begin
         float_evt = 1'b1;
      end
      if (pins_live && !float_s && st.float_prev && i_float_falling_irq_enable) begin
         float_evt = 1'b1;
      end
   end

   // new value of the conversion register for write, set and clear aliases
   always_comb begin
      case (cmd_addr)
         ADDR_CONV_SET: begin
            conv_new = conv_byte | (i_acc.wdata & CONV_WRITE_MASK);
         end
         ADDR_CONV_CLEAR: begin
            conv_new = conv_byte & ~(i_acc.wdata & CONV_WRITE_MASK);
         end
         default: begin
            conv_new = (conv_byte & ~CONV_WRITE_MASK) | (i_acc.wdata & CONV_WRITE_MASK);
         end
      endcase
   end

   // next state of the whole bank
   always_comb begin
      next_st = st;
      next_st.float_prev = float_s;
      // warm-up count stops once the pins are trusted
      if (!pins_live) begin
         next_st.warm = st.warm + 2'h1;
      end
      // read answer, one cycle after the command; unmapped reads give zero
      next_st.rsp.valid = acc_rd;
      next_st.rsp.rdata = 8'h00;
      if (acc_rd) begin
         if (cmd_addr == ADDR_EVENT_LATCH) begin
            // only bits 0 and 3 exist, the rest read zero
            next_st.rsp.rdata[LATCH_FLOAT_BIT] = st.id_float_event_flag;
            next_st.rsp.rdata[LATCH_DONE_BIT] = st.resistor_done_event_flag;
         end else if (is_vendor_addr(cmd_addr)) begin
            if (cmd_addr == ADDR_BOOST) begin
               next_st.rsp.rdata[BOOST_LSB +: 2] = st.boost;
            end else if (cmd_addr == ADDR_AUDIO_KEY) begin
               next_st.rsp.rdata[3:0] = st.audio_mode_key;
            end else if (is_conv_addr(cmd_addr)) begin
               next_st.rsp.rdata = conv_byte;
            end
         end
      end
      // register writes; the latch address ignores writes
      if (acc_wr && is_vendor_addr(cmd_addr)) begin
         if (cmd_addr == ADDR_BOOST) begin
            next_st.boost = i_acc.wdata[BOOST_LSB +: 2];
         end else if (cmd_addr == ADDR_AUDIO_KEY) begin
            next_st.audio_mode_key = i_acc.wdata[3:0];
         end else if (is_conv_addr(cmd_addr)) begin
            next_st.resistor_code = conv_new[2:0];
            next_st.resistor_measure_go = conv_new[CONV_GO_BIT];
            next_st.rsv5 = conv_new[CONV_RSV_BIT];
            next_st.resistor_done_irq_enable = conv_new[CONV_IEN_BIT];
         end
      end
      // a read through the conversion register consumes the done flag;
      // other readers use the output copy and leave it alone
      if (acc_rd && is_conv_addr(cmd_addr)) begin
         next_st.resistor_measure_done = 1'b0;
      end
      // converter sequencing; completion placed after the read so it wins
      case (st.conv)
         CONV_IDLE: begin
            if (next_st.resistor_measure_go) begin
               next_st.conv = CONV_RUN;
            end
         end
         CONV_RUN: begin
            if (conv_fin) begin
               next_st.resistor_code = code_s;
               next_st.resistor_measure_done = 1'b1;
               next_st.resistor_measure_go = 1'b0;
               next_st.conv = CONV_IDLE;
            end else if (!next_st.resistor_measure_go) begin
               // link cleared go: abandon the measurement
               next_st.conv = CONV_IDLE;
            end
         end
         default: begin
            next_st.conv = CONV_IDLE;
         end
      endcase
      // latch: clear on read first, then new events so a racing event survives
      if (acc_rd && (cmd_addr == ADDR_EVENT_LATCH)) begin
         next_st.id_float_event_flag = 1'b0;
         next_st.resistor_done_event_flag = 1'b0;
      end
      if (float_evt) begin
         next_st.id_float_event_flag = 1'b1;
      end
      if (done_evt) begin
         next_st.resistor_done_event_flag = 1'b1;
      end
      next_st.audio_en = (next_st.audio_mode_key == AUDIO_KEY_VALUE);
      next_st.alt_int = next_st.id_float_event_flag | next_st.resistor_done_event_flag;
   end

   // done rising edge qualified by the combined enable
   always_comb begin
      done_evt = (st.conv == CONV_RUN) && conv_fin && !st.resistor_measure_done && irq_en_any;
   end

   // state register
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // every output is a flop of the state
   assign o_rsp = st.rsp;
   assign o_alt_int = st.alt_int;
   assign o_boost = st.boost;
   assign o_audio_mode_en = st.audio_en;
   assign o_resistor_measure_go = st.resistor_measure_go;
   assign o_resistor_code = st.resistor_code;
   assign o_resistor_measure_done = st.resistor_measure_done;

   // checks
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_nrst);

   property p_float_rise;
      (pins_live && float_s && !st.float_prev && i_float_rising_irq_enable)
         |=> st.id_float_event_flag;
   endproperty
   a_float_rise: assert property (p_float_rise) else $error("float rise not latched");

   property p_float_fall;
      (pins_live && !float_s && st.float_prev && i_float_falling_irq_enable)
         |=> st.id_float_event_flag;
   endproperty
   a_float_fall: assert property (p_float_fall) else $error("float fall not latched");

   property p_latch_clear;
      (acc_rd && cmd_addr == ADDR_EVENT_LATCH && !float_evt && !done_evt)
         |=> !st.id_float_event_flag && !st.resistor_done_event_flag;
   endproperty
   a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared by read");

   property p_done_latch;
      (conv_fin && st.conv == CONV_RUN && !st.resistor_measure_done && irq_en_any)
         |=> st.resistor_done_event_flag && o_alt_int;
   endproperty
   a_done_latch: assert property (p_done_latch) else $error("done event not latched");

   property p_latch_zero_bits;
      (acc_rd && cmd_addr == ADDR_EVENT_LATCH)
         |=> o_rsp.valid && ((o_rsp.rdata & ~LATCH_READ_MASK) == 8'h00);
   endproperty
   a_latch_zero_bits: assert property (p_latch_zero_bits) else $error("latch spare bits set");

   property p_boost_write;
      (acc_wr && cmd_addr == ADDR_BOOST) |=> (o_boost == $past(i_acc.wdata[BOOST_LSB +: 2]));
   endproperty
   a_boost_write: assert property (p_boost_write) else $error("boost field not stored");

   property p_audio_key;
      (acc_wr && cmd_addr == ADDR_AUDIO_KEY) |=> (o_audio_mode_en == ($past(i_acc.wdata[3:0]) == 4'ha));
   endproperty
   a_audio_key: assert property (p_audio_key) else $error("audio enable wrong for key");

   property p_finish;
      (conv_fin && st.conv == CONV_RUN) |=> o_resistor_measure_done && !o_resistor_measure_go
         && (o_resistor_code == $past(code_s));
   endproperty
   a_finish: assert property (p_finish) else $error("conversion end not reported");

   property p_done_read_clear;
      (acc_rd && is_conv_addr(cmd_addr) && !conv_fin) |=> !o_resistor_measure_done;
   endproperty
   a_done_read_clear: assert property (p_done_read_clear) else $error("done kept after read");

   property p_go_start;
      (acc_wr && cmd_addr == ADDR_CONV_SET && i_acc.wdata[CONV_GO_BIT] && st.conv == CONV_IDLE
         && !conv_fin) |=> o_resistor_measure_go ##1 (st.conv == CONV_RUN);
   endproperty
   a_go_start: assert property (p_go_start) else $error("set of go did not start");

   property p_read_race;
      (acc_rd && cmd_addr == ADDR_EVENT_LATCH && float_evt)
         |=> st.id_float_event_flag && o_alt_int;
   endproperty
   a_read_race: assert property (p_read_race) else $error("event lost to latch read");

   c_conversion: cover property (st.conv == CONV_RUN ##1 conv_fin);
   c_float_event: cover property (float_evt ##1 o_alt_int);
   c_audio_on: cover property ($rose(o_audio_mode_en));
   c_read_race: cover property (acc_rd && cmd_addr == ADDR_EVENT_LATCH && float_evt);
endmodule

// *** test/idrd_link_model.sv ***
// link-side model that issues immediate register commands to the bank
`timescale 1ns/10ps
module idrd_link_model
   import idrd_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_nrst,
   output idrd_acc_t o_acc
);
   idrd_acc_t cmd_q[$]; // queued commands, one issued per cycle
   // the id pin pull-up is assumed enabled by the link elsewhere
   // immediate write: kind 10 in cmd[7:6], address below
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      // reserved bit 5 of the conversion register is always sent as zero
      if (a >= ADDR_CONV_WRITE && a <= ADDR_CONV_CLEAR) begin
         v[CONV_RSV_BIT] = 1'b0;
      end
      cmd_q.push_back('{1'b1, {CMD_REG_WRITE, a}, v});
   endtask
   // immediate read: kind 11 in cmd[7:6]
   task automatic rd(input logic [5:0] a);
      cmd_q.push_back('{1'b1, {CMD_REG_READ, a}, 8'h00});
   endtask
   function automatic int pending();
      return cmd_q.size();
   endfunction
   // back-to-back commands are legal; idle cycles show inverted stale
   // command and data so a stale value can never pass for a live one
   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_acc <= '0;
      end else if (cmd_q.size() > 0) begin
         o_acc <= cmd_q.pop_front();
      end else begin
         o_acc <= '{1'b0, ~o_acc.cmd, ~o_acc.wdata};
      end
   end
endmodule

// *** test/tb_idrd_regs.sv ***
// self-checking bench for the id float and resistor conversion register bank
`timescale 1ns/10ps
module tb_idrd_regs;
   import idrd_pkg::*;
   localparam int CONV_P = 20; // short conversion keeps the run brief
   logic i_mclk;
   logic i_nrst;
   idrd_acc_t acc;
   idrd_rsp_t rsp;
   logic id_float;
   logic [2:0] code_pin;
   logic rise_en;
   logic fall_en;
   logic car_en;
   logic alt_int;
   logic [1:0] boost;
   logic audio_en;
   logic go;
   logic [2:0] code;
   logic done;
   logic [7:0] exp_q[$]; // expected read answers, oldest first
   logic [7:0] r;
   logic [2:0] c;
   int k;
   int n;
   int n_errors = 0;
   int checks = 0;
   int cyc = 0;
   logic [5:0] raddr [7] = '{6'h21, 6'h31, 6'h33, 6'h36, 6'h37, 6'h38, 6'h3f};
   logic [2:0] codes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
   // float steps: {pin level, rise enable, fall enable, latch expected}
   logic [3:0] ftab [4] = '{4'hd, 4'h4, 4'ha, 4'h3};

   idrd_regs #(.CONV_CYCLES_P(CONV_P)) idrd_regs_inst (
      .i_mclk(i_mclk), .i_nrst(i_nrst), .i_acc(acc), .i_id_float(id_float),
      .i_resistor_code_pin(code_pin), .i_float_rising_irq_enable(rise_en),
      .i_float_falling_irq_enable(fall_en), .i_carkit_resistor_irq_enable(car_en),
      .o_rsp(rsp), .o_alt_int(alt_int), .o_boost(boost), .o_audio_mode_en(audio_en),
      .o_resistor_measure_go(go), .o_resistor_code(code), .o_resistor_measure_done(done)
   );
   idrd_link_model idrd_link_model_inst (.i_mclk(i_mclk), .i_nrst(i_nrst), .o_acc(acc));

   // 40 mhz clock
   initial begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end

   task automatic err(input string m);
      n_errors++;
      $display("ERROR %0t %s", $time, m);
   endtask
   task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) err($sformatf("read %h expected %h", got, exp));
   endtask
   task automatic chk_out(input logic [7:0] got, input logic [7:0] exp, input string m);
      checks++;
      if (got !== exp) err($sformatf("%s %h expected %h", m, got, exp));
   endtask
   task automatic final_report;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // note the expected answer, then queue the read at the link
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      idrd_link_model_inst.rd(a);
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      idrd_link_model_inst.wr(a, d);
   endtask
   // wait, bounded, until the link queue drains and answers have landed
   task automatic flush;
      int m = 0;
      while (idrd_link_model_inst.pending() != 0 && m < 100) begin
         @(negedge i_mclk);
         m++;
      end
      repeat (3) @(negedge i_mclk);
   endtask

   // watcher: each read answer is matched against the oldest note
   always @(negedge i_mclk) begin
      if (rsp.valid === 1'b1) begin
         if (exp_q.size() == 0) err("unexpected read answer");
         else chk_rd(rsp.rdata, exp_q.pop_front());
      end
   end
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         final_report();
      end
   end

   initial begin
      i_nrst = 1'b0;
      id_float = 1'b0;
      code_pin = 3'h0;
      rise_en = 1'b0;
      fall_en = 1'b0;
      car_en = 1'b0;
      void'($urandom(25));
      repeat (2) @(posedge i_mclk);
      i_nrst <= 1'b1;
      // writes to the read-only latch and an unmapped place must not stick
      wr(ADDR_EVENT_LATCH, 8'hff);
      wr(6'h3f, 8'hff);
      foreach (raddr[i]) rd(raddr[i], 8'h00);
      flush();
      // every boost code, reserved bits filled with noise
      for (k = 0; k < 4; k++) begin
         r = 8'($urandom);
         wr(ADDR_BOOST, {r[7], 2'(k), r[4:0]});
         rd(ADDR_BOOST, {1'b0, 2'(k), 5'h00});
         flush();
         chk_out(8'(boost), 8'(k), "boost");
      end
      // audio key: only 1010 in bits 3:0 enables the mode
      for (k = 0; k < 6; k++) begin
         r = 8'($urandom);
         if (k < 2) r[3:0] = 4'ha;
         wr(ADDR_AUDIO_KEY, r);
         rd(ADDR_AUDIO_KEY, {4'h0, r[3:0]});
         flush();
         chk_out(8'(audio_en), 8'(r[3:0] == 4'ha), "audio");
      end
      // conversions: local enable, carkit enable, then neither
      for (k = 0; k < 3; k++) begin
         // a fresh nonzero code each pass, so a missed capture always shows
         c = codes[k * 2 + 1 + int'($urandom % 2)];
         @(posedge i_mclk);
         code_pin <= c;
         car_en <= (k == 1);
         if (k == 0) begin
            wr(ADDR_CONV_WRITE, 8'h70);
         end else begin
            if (k == 1) wr(ADDR_CONV_CLEAR, 8'h40);
            wr(ADDR_CONV_SET, 8'h10);
         end
         flush();
         chk_out(8'(go), 8'h01, "go");
         chk_out(8'(done), 8'h00, "done early");
         n = 0;
         while (done !== 1'b1 && n < CONV_P + 20) begin
            @(negedge i_mclk);
            n++;
         end
         chk_out(8'(done), 8'h01, "done");
         chk_out(8'(go), 8'h00, "go clear");
         chk_out(8'(code), 8'(c), "code");
         chk_out(8'(alt_int), 8'(k < 2), "alt_int");
         rd(ADDR_EVENT_LATCH, (k < 2) ? 8'h08 : 8'h00);
         flush();
         chk_out(8'(done), 8'h01, "done kept");
         rd(ADDR_CONV_WRITE, {1'b0, k == 0, 2'b00, 1'b1, c});
         flush();
         rd(ADDR_CONV_CLEAR, {1'b0, k == 0, 2'b00, 1'b0, c});
         flush();
         chk_out(8'(done), 8'h00, "done clear");
         chk_out(8'(alt_int), 8'h00, "alt_int clear");
      end
      // id float edges under each enable
      for (k = 0; k < 4; k++) begin
         @(posedge i_mclk);
         rise_en <= ftab[k][2];
         fall_en <= ftab[k][1];
         @(posedge i_mclk);
         id_float <= ftab[k][3];
         repeat (8) @(negedge i_mclk);
         chk_out(8'(alt_int), 8'(ftab[k][0]), "float alt_int");
         rd(ADDR_EVENT_LATCH, {7'h00, ftab[k][0]});
         flush();
         chk_out(8'(alt_int), 8'h00, "latch clear");
      end
      // a float edge seen in the very cycle the latch read is taken must survive;
      // the pin moves two edges before the synchronised edge, the read lands then
      @(posedge i_mclk);
      rise_en <= 1'b1;
      @(posedge i_mclk);
      id_float <= 1'b1;
      repeat (2) @(negedge i_mclk);
      rd(ADDR_EVENT_LATCH, 8'h00);
      flush();
      chk_out(8'(alt_int), 8'h01, "race kept");
      rd(ADDR_EVENT_LATCH, 8'h01);
      flush();
      chk_out(8'(alt_int), 8'h00, "race clear");
      chk_out(8'(exp_q.size()), 8'h00, "answers missing");
      final_report();
   end
endmodule
